/* logic/lwdt_pkg.sv */
`include "lwdt_regs.svh"

package lwdt_pkg;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_OFF  = 3'b010,
        ST_FIRE = 3'b100
    } lwdt_state_e;

    typedef struct packed {
        logic                     enable;
        logic [`LWDT_SEL_W-1:0]   interval;
    } lwdt_cfg_s;

    typedef struct packed {
        logic                     enabled;
        logic                     locked;
        logic [`LWDT_SEL_W-1:0]   interval;
    } lwdt_status_s;

endpackage : lwdt_pkg

/* logic/lwdt_regs.svh */
`ifndef LWDT_REGS_SVH
`define LWDT_REGS_SVH

// ==========================================================
// Interval selection
`define LWDT_SEL_W        3
`define LWDT_SEL_DEFAULT  3'h7
`define LWDT_CNT_W        21
`define LWDT_SHIFT_BASE   5'h06

// ==========================================================
// Reset request pulse
`define LWDT_FIRE_CYCLES  4'h4
`define LWDT_FIRE_W       4

`endif

/* logic/lwdt_tick.sv */
`timescale 1ns/1ps

// ==========================================================
// Oscillator synchroniser and rising edge pulse
module lwdt_tick (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic nrst_i,
    // Asynchronous oscillator
    input  wire logic low_freq_oscillator_i,
    // One cycle per oscillator rising edge
    output logic      tick_o
);

    logic sync_a;
    logic sync_b;
    logic sync_c;

    // Edge is taken between second and third stage only
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            sync_a <= low_freq_oscillator_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
            tick_o <= sync_b & ~sync_c;
        end
    end

endmodule : lwdt_tick

/* logic/lwdt_top.sv */
// Operation
// - Counter advances on low-frequency oscillator edges only
// - Overflow forces whole microcontroller into reset
// - After reset: enabled, counting, maximum interval
// - Software selects timeout from programmable set
// - Software may disable while unlocked
// - Locked watchdog ignores disable until reset
// - Lock blocks every configuration change until reset
// - Watchdog reset never touches external reset pin
`timescale 1ns/1ps
`include "lwdt_regs.svh"

module lwdt_top (
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 nrst_i,
    // Low-frequency oscillator pin
    input  wire logic                 low_freq_oscillator_i,
    // Software control
    input  wire logic                 restart_i,
    input  wire logic                 cfg_wr_i,
    input  wire lwdt_pkg::lwdt_cfg_s  cfg_i,
    input  wire logic                 lock_i,
    // Reset request and status
    output logic                      sys_reset_req_o,
    output logic                      ext_rst_pin_oe_o,
    output lwdt_pkg::lwdt_status_s    status_o
);

    // ==========================================================
    // Interval decode: 4^(3+sel) oscillator ticks
    function automatic logic [`LWDT_CNT_W-1:0] limit_of(input logic [`LWDT_SEL_W-1:0] sel);
        logic [4:0] sh;
        sh = `LWDT_SHIFT_BASE + {1'b0, sel, 1'b0};
        limit_of = (`LWDT_CNT_W'(1) << sh) - `LWDT_CNT_W'(1);
    endfunction : limit_of

    // ==========================================================
    // State
    lwdt_pkg::lwdt_state_e        state;
    lwdt_pkg::lwdt_state_e        next_state;
    logic [`LWDT_CNT_W-1:0]       count;
    logic [`LWDT_CNT_W-1:0]       next_count;
    logic [`LWDT_SEL_W-1:0]       interval;
    logic [`LWDT_SEL_W-1:0]       next_interval;
    logic                         locked;
    logic                         next_locked;
    logic [`LWDT_FIRE_W-1:0]      fire_cnt;
    logic [`LWDT_FIRE_W-1:0]      next_fire_cnt;
    logic                         tick;

    lwdt_tick u_tick (
        .sys_clk_i             (sys_clk_i),
        .nrst_i                (nrst_i),
        .low_freq_oscillator_i (low_freq_oscillator_i),
        .tick_o                (tick)
    );

    // ==========================================================
    // Decode
    wire running    = (state == lwdt_pkg::ST_RUN);
    wire firing     = (state == lwdt_pkg::ST_FIRE);
    wire cfg_ok     = cfg_wr_i & ~locked & ~firing;
    wire lock_take  = lock_i & ~firing;
    wire overflow   = running & tick & ~restart_i
                      & (count == limit_of(interval));
    wire fire_done  = firing & (fire_cnt == `LWDT_FIRE_CYCLES - `LWDT_FIRE_W'(1));

    // Restart has priority over a tick in the same cycle
    assign next_count = (restart_i | ~running | cfg_ok) ? '0 :
                        tick ? count + `LWDT_CNT_W'(1) : count;

    assign next_interval = fire_done ? `LWDT_SEL_DEFAULT :
                           cfg_ok    ? cfg_i.interval : interval;

    // Locking holds the watchdog on; forced reset releases the lock
    assign next_locked   = fire_done ? 1'b0 : (locked | lock_take);

    assign next_fire_cnt = firing ? fire_cnt + `LWDT_FIRE_W'(1) : '0;

    always_comb begin
        next_state = state;
        case (state)
            lwdt_pkg::ST_RUN: begin
                if (overflow)
                    next_state = lwdt_pkg::ST_FIRE;
                else if (cfg_ok & ~cfg_i.enable & ~lock_take)
                    next_state = lwdt_pkg::ST_OFF;
            end
            lwdt_pkg::ST_OFF: begin
                if (lock_take | (cfg_ok & cfg_i.enable))
                    next_state = lwdt_pkg::ST_RUN;
            end
            lwdt_pkg::ST_FIRE: begin
                if (fire_done)
                    next_state = lwdt_pkg::ST_RUN;
            end
            default: next_state = lwdt_pkg::ST_RUN;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state    <= lwdt_pkg::ST_RUN;
            count    <= '0;
            interval <= `LWDT_SEL_DEFAULT;
            locked   <= 1'b0;
            fire_cnt <= '0;
        end else begin
            state    <= next_state;
            count    <= next_count;
            interval <= next_interval;
            locked   <= next_locked;
            fire_cnt <= next_fire_cnt;
        end
    end

    // ==========================================================
    // Outputs, all registered
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sys_reset_req_o  <= 1'b0;
            ext_rst_pin_oe_o <= 1'b0;
            status_o         <= '{enabled: 1'b1, locked: 1'b0, interval: `LWDT_SEL_DEFAULT};
        end else begin
            sys_reset_req_o  <= (next_state == lwdt_pkg::ST_FIRE);
            ext_rst_pin_oe_o <= 1'b0;
            status_o.enabled  <= (next_state != lwdt_pkg::ST_OFF);
            status_o.locked   <= next_locked;
            status_o.interval <= next_interval;
        end
    end

endmodule : lwdt_top

/* verification/lwdt_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Port level checks of the watchdog
module lwdt_props (
    // Clock and reset
    input wire logic                   sys_clk_i,
    input wire logic                   nrst_i,
    // Oscillator and software control
    input wire logic                   low_freq_oscillator_i,
    input wire logic                   restart_i,
    input wire logic                   cfg_wr_i,
    input wire lwdt_pkg::lwdt_cfg_s    cfg_i,
    input wire logic                   lock_i,
    // Reset request and status
    input wire logic                   sys_reset_req_o,
    input wire logic                   ext_rst_pin_oe_o,
    input wire lwdt_pkg::lwdt_status_s status_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_PIN: assert property (!ext_rst_pin_oe_o)
        else $error("reset pin driven");
    AST_PULSE: assert property ($rose(sys_reset_req_o) |-> sys_reset_req_o[*4] ##1 !sys_reset_req_o)
        else $error("reset request length wrong");
    AST_DFLT: assert property ($fell(sys_reset_req_o) |-> status_o == 5'h17)
        else $error("defaults not restored");
    AST_CFG: assert property (cfg_wr_i && !lock_i && !status_o.locked && !sys_reset_req_o
        |=> status_o.enabled == $past(cfg_i.enable) && status_o.interval == $past(cfg_i.interval))
        else $error("config write lost");
    AST_ROSE: assert property ($rose(sys_reset_req_o) |-> $past(status_o.enabled))
        else $error("request while disabled");
    AST_LKON: assert property (lock_i && !sys_reset_req_o |=> status_o.locked && status_o.enabled)
        else $error("lock not taken");
    AST_LOCK: assert property (status_o.locked |=> $stable(status_o) || $fell(sys_reset_req_o))
        else $error("locked state changed");
    AST_HOLD: assert property (!cfg_wr_i && !lock_i && !sys_reset_req_o |=> $stable(status_o))
        else $error("status moved unasked");
    AST_RST: assert property (restart_i && !sys_reset_req_o |=> !sys_reset_req_o)
        else $error("restart did not prevent overflow");
endmodule : lwdt_props

bind lwdt_top lwdt_props u_props (.sys_clk_i, .nrst_i, .low_freq_oscillator_i, .restart_i,
    .cfg_wr_i, .cfg_i, .lock_i, .sys_reset_req_o, .ext_rst_pin_oe_o, .status_o);

/* verification/lwdt_top_tb_top.sv */
`timescale 1ns/1ps
module lwdt_top_tb_top;
    // ==========================================================
    // Signals
    logic                   sys_clk_i = 0, nrst_i = 0, osc = 0, run_osc = 1;
    logic                   restart_i = 0, cfg_wr_i = 0, lock_i = 0;
    logic                   sys_reset_req_o, ext_rst_pin_oe_o;
    lwdt_pkg::lwdt_cfg_s    cfg_i = '0;
    lwdt_pkg::lwdt_status_s status_o, last = 5'h17, cur = 5'h17;
    logic [4:0]             exp_q[$];
    logic [7:0]             rnd = 8'h4b;
    int                     num_errors = 0, n_checks = 0, cycles = 0;

    lwdt_top u_dut (.sys_clk_i, .nrst_i, .low_freq_oscillator_i(osc), .restart_i,
        .cfg_wr_i, .cfg_i, .lock_i, .sys_reset_req_o, .ext_rst_pin_oe_o, .status_o);

    initial forever #20 sys_clk_i = ~sys_clk_i;
    // Oscillator at a quarter rate keeps the shortest timeout near 256 cycles
    always @(negedge sys_clk_i) begin
        cycles++;
        if (run_osc && cycles[0]) osc <= ~osc;
        if (cycles == 4000) begin
            num_errors++;
            complete_run();
        end
        if (status_o !== last) begin
            chk(exp_q.size() ? exp_q.pop_front() : last, status_o);
            last = status_o;
        end
    end

    // ==========================================================
    // Tasks
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task chk(input logic [4:0] e, input logic [4:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    task wt(input int n);
        cfg_wr_i = 0;
        lock_i = 0;
        restart_i = 0;
        repeat (n) @(negedge sys_clk_i);
    endtask : wt
    task op(input logic w, input logic [3:0] c, input logic l, input logic [4:0] e);
        cfg_wr_i = w;
        cfg_i = c;
        lock_i = l;
        if (e != cur) exp_q.push_back(e);
        cur = e;
        @(negedge sys_clk_i);
    endtask : op
    // Window of 240 to 300 cycles brackets 64 ticks plus latency
    task ovf;
        restart_i = 1;
        @(negedge sys_clk_i);
        wt(1);
        exp_q.push_back(5'h17);
        cur = 5'h17;
        wt(238);
        chk(5'(exp_q.size()), 5'h01);
        for (int i = 0; i < 60 && exp_q.size() > 0; i++) wt(1);
        chk(5'(exp_q.size()), 5'h00);
    endtask : ovf
    task complete_run;
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // ==========================================================
    // Scenarios
    initial begin
        wt(10);
        nrst_i = 1;
        wt(2);
        chk(5'h17, status_o);
        for (int i = 0; i < 4; i++) begin
            op(1'h1, {1'h1, rnd[2:0]}, 1'h0, {2'h2, rnd[2:0]});
            rnd = lfsr(rnd);
        end
        op(1'h1, 4'h0, 1'h0, 5'h00);
        wt(400);
        op(1'h1, 4'h8, 1'h0, 5'h10);
        run_osc = 0;
        wt(400);
        run_osc = 1;
        for (int i = 0; i < 3; i++) begin
            restart_i = 1;
            @(negedge sys_clk_i);
            wt(200);
        end
        ovf();
        op(1'h1, 4'h8, 1'h0, 5'h10);
        op(1'h0, 4'h0, 1'h1, 5'h18);
        for (int i = 0; i < 4; i++) begin
            op(1'h1, rnd[3:0], 1'h0, 5'h18);
            rnd = lfsr(rnd);
        end
        op(1'h1, 4'h0, 1'h1, 5'h18);
        ovf();
        op(1'h0, 4'h0, 1'h1, 5'h1f);
        wt(2);
        exp_q.push_back(5'h17);
        nrst_i = 0;
        wt(4);
        nrst_i = 1;
        wt(2);
        chk(5'(exp_q.size()), 5'h00);
        complete_run();
    end
endmodule : lwdt_top_tb_top
